// File: shared/swt_pkg.sv
package swt_pkg;
	// Register offsets
	localparam logic [7:0] ADDR_MODE = 8'h4D;
	localparam logic [7:0] ADDR_CFG  = 8'h55;
	localparam logic [7:0] ADDR_UID  = 8'h5C;
	localparam logic [7:0] ADDR_LOCK = 8'h5D;
	localparam logic [7:0] ADDR_REV  = 8'h65;

	// Mode register fields
	localparam int MODE_SWDIS_B  = 0;
	localparam int MODE_MARGIN_B = 1;
	localparam int MODE_EWOV_B   = 2;
	localparam int MODE_INDEP_B  = 3;

	// Watchdog configuration fields
	localparam int CFG_TO_LSB   = 0;
	localparam int CFG_SD_LSB   = 3;
	localparam int CFG_EN_B     = 5;
	localparam int CFG_SDEN_B   = 6;
	localparam int CFG_RSTEN_B  = 7;

	// Lock register fields
	localparam int LOCK_CFG_B = 0;
	localparam int LOCK_NV_B  = 1;

	// Reset values; software disable bit powers up set (sequencing disabled)
	localparam logic [7:0] MODE_RST = 8'h01;
	localparam logic [7:0] CFG_RST  = 8'h00;
	localparam logic [7:0] UID_RST  = 8'h00;
	localparam logic [1:0] LOCK_RST = 2'h0;

	// Protected nonvolatile range while fault data is locked
	localparam logic [7:0] NV_PROT_HI = 8'h11;

	// Timing: 25 MHz clock, 250 us timer tick
	localparam int CLK_NS      = 40;
	localparam int TICK_US     = 250;
	localparam int TICK_CYC_DEF = (TICK_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int T_RP_NS     = 25000;
	localparam int RP_CYC      = (T_RP_NS + CLK_NS - 1) / CLK_NS;
	localparam int WDO_LOW_CYC = 3;
	localparam int CNT_W       = 20;

	// Normal timeouts in microseconds, startup delays in milliseconds
	localparam int T_WD_US [8] = '{1500, 6000, 18750, 75000, 300000, 1200000, 2400000, 4800000};
	localparam int T_SD_MS [4] = '{38400, 16800, 153600, 192000};

	typedef enum logic [4:0] {
		ST_HOLD  = 5'b00001,
		ST_START = 5'b00010,
		ST_RUN   = 5'b00100,
		ST_FAULT = 5'b01000,
		ST_PULSE = 5'b10000
	} swt_state_t;

	// Timeout in ticks for a configuration code
	function automatic logic [CNT_W-1:0] swt_wd_ticks(input logic [2:0] code);
		swt_wd_ticks = CNT_W'(T_WD_US[code] / TICK_US);
	endfunction : swt_wd_ticks

	// Startup delay in ticks for a configuration code
	function automatic logic [CNT_W-1:0] swt_sd_ticks(input logic [1:0] code);
		swt_sd_ticks = CNT_W'(T_SD_MS[code] * 1000 / TICK_US);
	endfunction : swt_sd_ticks
endpackage : swt_pkg

// File: design/swt_watchdog.sv
`timescale 1ns/1ps
// Function
// - Mode bit 3 selects dependent (0) or independent (1) watchdog operation.
// - Dependent mode stays inactive until sequencing completes and system reset releases.
// - Independent mode starts after lockout and boot; sequencer resets do not affect it.
// - Configuration bit 6 enables the long startup delay; clear skips it.
// - Configuration bits 4:3 select startup delay 38.4, 16.8, 153.6 or 192 s.
// - Configuration bits 2:0 select timeout 1.5 ms through 4800 ms.
// - The first strobe edge during startup begins normal timeout supervision.
// - Host toggles strobe; missing edge within timeout asserts the fault output.
// - Fault stays asserted until the next strobe edge or, in dependent mode, system reset.
// - Dependent mode holds the timer in reset while enable input is low.
// - Dependent mode clears timer and fault while system reset is asserted.
// - Configuration bit 5 enables supervision; clearing it disables the watchdog.
// - With reset output enabled, expiry pulses system reset and briefly pulses fault.
// - With reset output disabled, expiry asserts only the fault output.
// - Expiry order: fault, then reset, then fault release; fault low three cycles.
// - In dependent mode, every reset event restarts the startup delay after sequencing completes.
// - Mode bit 0 low permits sequencing with enable high; high disables it.
// - Mode bit 1 enables margining; bit 2 picks overvoltage early warning.
// - Configuration lock refuses configuration and nonvolatile writes except lock register.
// - Fault log sets data lock flag, which protects nonvolatile addresses 00h to 11h.
// - Writing one to a lock bit inverts it; writing zero leaves it.
// - User identification byte and read-only 3-bit revision field are provided.
module swt_watchdog
	import swt_pkg::*;
#(
	parameter int          TICK_CYC = TICK_CYC_DEF,
	parameter logic [2:0]  REV_CODE = 3'h0 // Arbitrary revision value
) (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       strobe_input_i,
	input  wire logic       enable_pin_i,
	input  wire logic       manual_reset_input_n_i,
	input  wire logic       seq_done_i,
	input  wire logic       sys_reset_i,
	input  wire logic       boot_done_i,
	input  wire logic       sw_reboot_i,
	input  wire logic       fault_log_trig_i,
	input  wire logic       reg_wr_i,
	input  wire logic [7:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	input  wire logic       nv_wr_i,
	input  wire logic [7:0] nv_addr_i,
	output logic      [7:0] reg_rdata_o,
	output logic            reg_wr_refused_o,
	output logic            nv_wr_grant_o,
	output logic            timeout_fault_output_n_o,
	output logic            wd_reset_o,
	output logic            seq_permit_o,
	output logic            margin_en_o,
	output logic            ew_overvolt_o
);

	typedef struct packed {
		logic [2:0]       strb_sync;
		logic [1:0]       en_sync;
		logic [1:0]       mr_sync;
		logic [7:0]       mode;
		logic [7:0]       cfg;
		logic [7:0]       uid;
		logic [1:0]       lock;
		logic [7:0]       rdata;
		logic             refused;
		logic             nv_grant;
		logic             seq_permit;
		swt_state_t       state;
		logic [15:0]      pres;
		logic [CNT_W-1:0] cnt;
		logic [9:0]       pc;
		logic             fault_n;
		logic             wd_reset;
	} swt_regs_t;

	swt_regs_t st_r;
	swt_regs_t st_nxt;

	logic indep;
	logic hold;
	logic edge_det;
	logic tick;
	logic cfg_wr;
	logic [CNT_W-1:0] to_ticks;
	logic [CNT_W-1:0] sd_ticks;

	// Mode decode and gating of the timer
	always_comb begin
		indep    = st_r.mode[MODE_INDEP_B];
		edge_det = st_r.strb_sync[1] ^ st_r.strb_sync[2];
		tick     = (st_r.pres == 16'(TICK_CYC - 1));
		to_ticks = swt_wd_ticks(st_r.cfg[CFG_TO_LSB +: 3]);
		sd_ticks = swt_sd_ticks(st_r.cfg[CFG_SD_LSB +: 2]);
		// Sequencer reset is ignored in independent mode, only boot matters
		if (indep) begin
			hold = !boot_done_i;
		end else begin
			hold = !st_r.en_sync[1] || sys_reset_i || !seq_done_i;
		end
		// Manual reset, reboot or disable restart everything
		hold = hold || !st_r.mr_sync[1] || sw_reboot_i || !st_r.cfg[CFG_EN_B];
		// Lock register stays writable so a locked part can still be unlocked
		cfg_wr = reg_wr_i && !st_r.lock[LOCK_CFG_B];
	end

	// Next state of every register in the block
	always_comb begin
		st_nxt = st_r;
		st_nxt.strb_sync = {st_r.strb_sync[1:0], strobe_input_i};
		st_nxt.en_sync   = {st_r.en_sync[0], enable_pin_i};
		st_nxt.mr_sync   = {st_r.mr_sync[0], manual_reset_input_n_i};
		st_nxt.refused   = 1'b0;

		// Register writes; lock register always writable by toggling
		if (reg_wr_i) begin
			case (reg_addr_i)
				ADDR_MODE: begin
					if (cfg_wr) st_nxt.mode = reg_wdata_i;
					st_nxt.refused = !cfg_wr;
				end
				ADDR_CFG: begin
					if (cfg_wr) st_nxt.cfg = reg_wdata_i;
					st_nxt.refused = !cfg_wr;
				end
				ADDR_UID: begin
					if (cfg_wr) st_nxt.uid = reg_wdata_i;
					st_nxt.refused = !cfg_wr;
				end
				ADDR_LOCK: st_nxt.lock = st_r.lock ^ reg_wdata_i[1:0];
				default: st_nxt.refused = 1'b1;
			endcase
		end
		// Fault log trigger wins over a same-cycle toggle
		if (fault_log_trig_i) st_nxt.lock[LOCK_NV_B] = 1'b1;

		// Registered read port; unmapped addresses and unused lock and revision bits read zero
		case (reg_addr_i)
			ADDR_MODE: st_nxt.rdata = st_r.mode;
			ADDR_CFG:  st_nxt.rdata = st_r.cfg;
			ADDR_UID:  st_nxt.rdata = st_r.uid;
			ADDR_LOCK: st_nxt.rdata = {6'h00, st_r.lock};
			ADDR_REV:  st_nxt.rdata = {5'h00, REV_CODE};
			default:   st_nxt.rdata = 8'h00;
		endcase

		// Nonvolatile write permission
		st_nxt.nv_grant = nv_wr_i && !st_r.lock[LOCK_CFG_B]
			&& !(st_r.lock[LOCK_NV_B] && nv_addr_i <= NV_PROT_HI);

		// Sequencing permit output; the analog mode outputs come straight from the mode register
		st_nxt.seq_permit = !st_r.mode[MODE_SWDIS_B] && st_r.en_sync[1];

		// Tick prescaler runs freely outside hold, where it sits at zero; a reload also restarts it
		// Tick granularity limits every period to whole tick multiples
		st_nxt.pres = tick ? 16'h0000 : st_r.pres + 16'h0001;
		if (tick && st_r.cnt != '0) st_nxt.cnt = st_r.cnt - CNT_W'(1);

		// Supervision state machine
		case (st_r.state)
			ST_HOLD: begin
				st_nxt.fault_n  = 1'b1;
				st_nxt.wd_reset = 1'b0;
				st_nxt.pres     = 16'h0000;
				// Every restart from hold reruns the startup delay when enabled
				if (!hold) begin
					if (st_r.cfg[CFG_SDEN_B]) begin
						st_nxt.state = ST_START;
						st_nxt.cnt   = sd_ticks;
					end else begin
						st_nxt.state = ST_RUN;
						st_nxt.cnt   = to_ticks;
					end
				end
			end
			ST_START, ST_RUN: begin
				// A strobe edge outranks an expiry in the same cycle
				if (edge_det) begin
					st_nxt.state = ST_RUN;
					st_nxt.cnt   = to_ticks;
					st_nxt.pres  = 16'h0000;
				end else if (tick && st_r.cnt <= CNT_W'(1)) begin
					st_nxt.fault_n = 1'b0;
					st_nxt.pc      = 10'h000;
					st_nxt.state   = st_r.cfg[CFG_RSTEN_B] ? ST_PULSE : ST_FAULT;
				end
			end
			ST_FAULT: begin
				// Fault holds until the host strobes again
				if (edge_det) begin
					st_nxt.fault_n = 1'b1;
					st_nxt.state   = ST_RUN;
					st_nxt.cnt     = to_ticks;
					st_nxt.pres    = 16'h0000;
				end
			end
			ST_PULSE: begin
				// Not abortable by hold: our own reset must complete its length
				st_nxt.pc       = st_r.pc + 10'h001;
				st_nxt.wd_reset = (st_r.pc < 10'(RP_CYC));
				st_nxt.fault_n  = (st_r.pc >= 10'(WDO_LOW_CYC - 1));
				if (st_r.pc == 10'(RP_CYC)) begin
					st_nxt.state = ST_HOLD;
				end
			end
			default: st_nxt.state = ST_HOLD;
		endcase

		// Any hold outside the reset pulse clears timer and fault
		if (hold && st_r.state != ST_PULSE) begin
			st_nxt.state    = ST_HOLD;
			st_nxt.fault_n  = 1'b1;
			st_nxt.wd_reset = 1'b0;
			st_nxt.cnt      = '0;
		end
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r            <= '0;
			// Synchronisers start at the pins' idle levels, so release gives no false edge
			st_r.strb_sync  <= 3'h0;
			st_r.en_sync    <= 2'h0;
			st_r.mr_sync    <= 2'h3;
			st_r.mode       <= MODE_RST;
			st_r.cfg        <= CFG_RST;
			st_r.uid        <= UID_RST;
			st_r.lock       <= LOCK_RST;
			st_r.state      <= ST_HOLD;
			st_r.fault_n    <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from flip-flops
	assign reg_rdata_o              = st_r.rdata;
	assign reg_wr_refused_o         = st_r.refused;
	assign nv_wr_grant_o            = st_r.nv_grant;
	assign timeout_fault_output_n_o = st_r.fault_n;
	assign wd_reset_o               = st_r.wd_reset;
	assign seq_permit_o             = st_r.seq_permit;
	assign margin_en_o              = st_r.mode[MODE_MARGIN_B];
	assign ew_overvolt_o            = st_r.mode[MODE_EWOV_B];

	// Checks sample on the system clock and sleep through reset
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_hold_clears_fault: assert property (
		hold && st_r.state != ST_PULSE |=> timeout_fault_output_n_o && st_r.state == ST_HOLD)
		else $error("hold did not clear fault");
	a_disable_stops: assert property (
		!st_r.cfg[CFG_EN_B] && st_r.state != ST_PULSE |=> st_r.state == ST_HOLD)
		else $error("disabled watchdog still active");
	a_wdo_low_three: assert property (
		$fell(timeout_fault_output_n_o) && st_r.state == ST_PULSE
		|-> (!timeout_fault_output_n_o)[*3] ##1 timeout_fault_output_n_o)
		else $error("fault pulse not three cycles");
	a_reset_after_fault: assert property (
		$fell(timeout_fault_output_n_o) && st_r.state == ST_PULSE |-> !wd_reset_o ##1 wd_reset_o)
		else $error("reset not one cycle after fault");
	a_no_reset_off: assert property (
		$rose(wd_reset_o) |-> $past(st_r.cfg[CFG_RSTEN_B], 2))
		else $error("reset pulsed while disabled");
	a_edge_reload: assert property (
		st_r.state inside {ST_START, ST_RUN, ST_FAULT} && edge_det && !hold
		|=> st_r.state == ST_RUN && st_r.cnt == $past(to_ticks))
		else $error("strobe edge did not reload");
	a_lock_refuse: assert property (
		reg_wr_i && reg_addr_i == ADDR_CFG && st_r.lock[LOCK_CFG_B] |=> $stable(st_r.cfg))
		else $error("locked config changed");
	a_lock_toggle: assert property (
		reg_wr_i && reg_addr_i == ADDR_LOCK && reg_wdata_i[0]
		|=> st_r.lock[LOCK_CFG_B] != $past(st_r.lock[LOCK_CFG_B]))
		else $error("lock bit did not toggle");
	a_nv_protect: assert property (
		nv_wr_i && st_r.lock[LOCK_NV_B] && nv_addr_i <= NV_PROT_HI |=> !nv_wr_grant_o)
		else $error("protected address granted");

	// Mode gating: sequencer signals only matter in dependent mode
	a_indep_free: assert property (
		indep && boot_done_i && st_r.mr_sync[1] && !sw_reboot_i && st_r.cfg[CFG_EN_B]
		|-> !hold)
		else $error("independent watchdog held by sequencer");
	a_dep_gated: assert property (
		!indep && (!st_r.en_sync[1] || !seq_done_i) && st_r.state != ST_PULSE
		|=> st_r.state == ST_HOLD)
		else $error("dependent watchdog ran ungated");

	// Fault output behaviour around expiry and strobe edges
	a_expiry_fault: assert property (
		st_r.state inside {ST_START, ST_RUN} && !edge_det && !hold
		&& tick && st_r.cnt <= CNT_W'(1) |=> !timeout_fault_output_n_o)
		else $error("expiry did not assert fault");
	a_fault_holds: assert property (
		st_r.state == ST_FAULT && !edge_det && !hold |=> !timeout_fault_output_n_o)
		else $error("fault released without strobe");
	a_fault_release: assert property (
		st_r.state == ST_FAULT && edge_det && !hold |=> timeout_fault_output_n_o)
		else $error("strobe did not release fault");
	a_fault_no_reset: assert property (
		st_r.state == ST_FAULT |-> !wd_reset_o)
		else $error("reset raised with reset output disabled");
	a_reset_length: assert property (
		$fell(wd_reset_o) |-> st_r.state == ST_HOLD && st_r.pc == 10'(RP_CYC + 1))
		else $error("reset pulse length wrong");

	// Counter loads on leaving hold, held against the raw period tables
	a_startup_load: assert property (
		st_r.state == ST_HOLD && !hold && st_r.cfg[CFG_SDEN_B]
		|=> st_r.state == ST_START && st_r.cnt ==
			CNT_W'(T_SD_MS[$past(st_r.cfg[CFG_SD_LSB +: 2])] * 1000 / TICK_US))
		else $error("startup delay not loaded");
	a_timeout_load: assert property (
		st_r.state == ST_HOLD && !hold && !st_r.cfg[CFG_SDEN_B]
		|=> st_r.state == ST_RUN && st_r.cnt ==
			CNT_W'(T_WD_US[$past(st_r.cfg[CFG_TO_LSB +: 3])] / TICK_US))
		else $error("timeout not loaded");

	// Register side effects
	a_swdis_blocks: assert property (
		st_r.mode[MODE_SWDIS_B] |=> !seq_permit_o)
		else $error("sequencing permitted while disabled");
	a_mode_bits: assert property (
		reg_wr_i && reg_addr_i == ADDR_MODE && !st_r.lock[LOCK_CFG_B]
		|=> margin_en_o == $past(reg_wdata_i[MODE_MARGIN_B])
		&& ew_overvolt_o == $past(reg_wdata_i[MODE_EWOV_B]))
		else $error("mode bits not applied");
	a_log_locks: assert property (
		fault_log_trig_i |=> st_r.lock[LOCK_NV_B])
		else $error("fault log did not set data lock");
	a_rev_readonly: assert property (
		reg_wr_i && reg_addr_i == ADDR_REV |=> reg_wr_refused_o)
		else $error("revision write not refused");
	a_tick_wraps: assert property (
		tick |=> st_r.pres == 16'h0000)
		else $error("prescaler did not wrap");

	c_start_to_run: cover property (st_r.state == ST_START ##1 st_r.state == ST_RUN);
	c_fault_held: cover property (st_r.state == ST_FAULT ##1 st_r.state == ST_RUN);
	c_reset_pulse: cover property ($rose(wd_reset_o));
	c_indep_ignore: cover property (indep && sys_reset_i && st_r.state == ST_RUN);
	c_hold_to_start: cover property (st_r.state == ST_HOLD ##1 st_r.state == ST_START);

endmodule : swt_watchdog

// File: verification/swt_host.sv
`timescale 1ns/1ps
// Host model: toggles the strobe pin freely, or gives one edge on request
module swt_host (
	input  wire logic clk_i,
	input  wire logic run_i,
	input  wire logic kick_i,
	output logic      strobe_o
);
	// Power-up state of the host counter and pin
	logic [3:0] cnt_r    = 4'h0;
	logic       strobe_r = 1'b0;
	// Free run toggles every 16 cycles, inside the shortest timeout
	always_ff @(posedge clk_i) begin
		cnt_r <= cnt_r + 4'h1;
		if ((run_i && cnt_r == 4'h0) || kick_i) begin
			strobe_r <= ~strobe_r;
		end
	end
	assign strobe_o = strobe_r;
endmodule : swt_host

// File: verification/supervisor_watchdog_timer_tb.sv
`timescale 1ns/1ps
module supervisor_watchdog_timer_tb;
	import swt_pkg::*;
	logic       clk_i = 1'b0;
	logic       rst_i = 1'b1;
	logic       run   = 1'b0;
	logic       kick  = 1'b0;
	logic       en    = 1'b1;
	logic       mr_n  = 1'b1;
	logic       sysr  = 1'b0;
	logic       seqd  = 1'b1;
	logic       bootd = 1'b1;
	logic       rbt   = 1'b0;
	logic       flog  = 1'b0;
	logic       wr    = 1'b0;
	logic       nvw   = 1'b0;
	logic [7:0] addr  = 8'h00;
	logic [7:0] wdat  = 8'h00;
	logic [7:0] nva   = 8'h00;
	logic [7:0] rdat;
	logic       strobe, refd, grant, fault_n, wdr, perm, marg, ewov;
	int         miscompares = 0;
	int         samples_checked = 0;
	int         k;
	localparam int TCYC = 4;
	// Clock at 25 MHz
	always #20 clk_i = ~clk_i;
	// Short tick so timeouts finish in tens of cycles; the revision value is arbitrary
	swt_watchdog #(.TICK_CYC(TCYC), .REV_CODE(3'h5)) i_swt_watchdog (.clk_i(clk_i),
		.rst_i(rst_i), .strobe_input_i(strobe), .enable_pin_i(en),
		.manual_reset_input_n_i(mr_n), .seq_done_i(seqd), .sys_reset_i(sysr),
		.boot_done_i(bootd), .sw_reboot_i(rbt),
		.fault_log_trig_i(flog), .reg_wr_i(wr), .reg_addr_i(addr), .reg_wdata_i(wdat),
		.nv_wr_i(nvw), .nv_addr_i(nva), .reg_rdata_o(rdat), .reg_wr_refused_o(refd),
		.nv_wr_grant_o(grant), .timeout_fault_output_n_o(fault_n), .wd_reset_o(wdr),
		.seq_permit_o(perm), .margin_en_o(marg), .ew_overvolt_o(ewov));
	swt_host i_swt_host (.clk_i(clk_i), .run_i(run), .kick_i(kick), .strobe_o(strobe));
	// Single comparison point; four-state compare so unknowns fail
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	// Register write, then the refusal flag one cycle later
	task automatic wreg(input logic [7:0] a, input logic [7:0] d, input logic rf);
		@(negedge clk_i);
		wr = 1'b1;
		addr = a;
		wdat = d;
		@(negedge clk_i);
		wr = 1'b0;
		chk(16'(refd), 16'(rf));
	endtask : wreg
	task automatic rreg(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk_i);
		addr = a;
		@(negedge clk_i);
		chk(16'(rdat), 16'(e));
	endtask : rreg
	task automatic nvwr(input logic [7:0] a, input logic e);
		@(negedge clk_i);
		nvw = 1'b1;
		nva = a;
		@(negedge clk_i);
		nvw = 1'b0;
		chk(16'(grant), 16'(e));
	endtask : nvwr
	// Bounded wait for the fault pin to reach a level
	task automatic wfault(input logic v, input int n);
		k = 0;
		while (fault_n !== v && k < n) begin
			@(negedge clk_i);
			k++;
		end
	endtask : wfault
	// One strobe edge from the host
	task automatic pulse_kick();
		@(negedge clk_i);
		kick = 1'b1;
		@(negedge clk_i);
		kick = 1'b0;
	endtask : pulse_kick
	task automatic t_regs();
		rreg(ADDR_MODE, MODE_RST);
		rreg(ADDR_CFG, CFG_RST);
		rreg(ADDR_LOCK, 8'h00);
		rreg(ADDR_REV, 8'h05);
		wreg(ADDR_UID, 8'hA5, 1'b0);
		rreg(ADDR_UID, 8'hA5);
		wreg(8'h70, 8'hFF, 1'b1);
		wreg(ADDR_MODE, 8'h06, 1'b0);
		repeat (3) @(negedge clk_i);
		chk(16'({perm, marg, ewov}), 16'h0007);
		en = 1'b0;
		repeat (4) @(negedge clk_i);
		chk(16'(perm), 16'h0000);
		en = 1'b1;
		wreg(ADDR_MODE, 8'h00, 1'b0);
	endtask : t_regs
	task automatic t_strobe();
		wfault(1'b0, 80);
		chk(16'(fault_n), 16'h0001);
		wreg(ADDR_CFG, 8'h20, 1'b0);
		run = 1'b1;
		wfault(1'b0, 200);
		chk(16'(fault_n), 16'h0001);
		run = 1'b0;
		wfault(1'b0, 60);
		chk(16'(fault_n), 16'h0000);
		repeat (20) @(negedge clk_i);
		chk(16'({fault_n, wdr}), 16'h0000);
		pulse_kick();
		wfault(1'b1, 8);
		chk(16'(fault_n), 16'h0001);
		en = 1'b0;
		wfault(1'b0, 100);
		chk(16'(fault_n), 16'h0001);
		en = 1'b1;
		wfault(1'b0, 60);
		chk(16'(fault_n), 16'h0000);
		sysr = 1'b1;
		wfault(1'b1, 8);
		chk(16'(fault_n), 16'h0001);
		wfault(1'b0, 100);
		chk(16'(fault_n), 16'h0001);
		seqd = 1'b0;
		sysr = 1'b0;
		wfault(1'b0, 100);
		chk(16'(fault_n), 16'h0001);
		sysr = 1'b1;
		seqd = 1'b1;
		wreg(ADDR_MODE, 8'h08, 1'b0);
		wfault(1'b0, 60);
		chk(16'(fault_n), 16'h0000);
		bootd = 1'b0;
		wfault(1'b1, 8);
		chk(16'(fault_n), 16'h0001);
		bootd = 1'b1;
		sysr = 1'b0;
	endtask : t_strobe
	task automatic t_rstout();
		wreg(ADDR_CFG, 8'hA0, 1'b0);
		pulse_kick();
		wfault(1'b1, 8);
		wfault(1'b0, 60);
		wfault(1'b1, 10);
		chk(16'(k), 16'(WDO_LOW_CYC));
		chk(16'(wdr), 16'h0001);
		k = 0;
		while (wdr === 1'b1 && k < 1000) begin
			@(negedge clk_i);
			k++;
		end
		chk(16'(k + 2), 16'(RP_CYC));
	endtask : t_rstout
	task automatic t_startup();
		wreg(ADDR_MODE, 8'h00, 1'b0);
		wreg(ADDR_CFG, 8'h68, 1'b0);
		mr_n = 1'b0;
		repeat (5) @(negedge clk_i);
		mr_n = 1'b1;
		wfault(1'b0, 300);
		chk(16'(fault_n), 16'h0001);
		pulse_kick();
		wfault(1'b0, 60);
		chk(16'(fault_n), 16'h0000);
		wreg(ADDR_CFG, 8'h21, 1'b0);
		pulse_kick();
		wfault(1'b1, 8);
		wfault(1'b0, 200);
		chk(16'(k), 16'(T_WD_US[1] / TICK_US * TCYC));
		wreg(ADDR_CFG, 8'h68, 1'b0);
		@(negedge clk_i);
		rbt = 1'b1;
		@(negedge clk_i);
		rbt = 1'b0;
		wfault(1'b0, 100);
		chk(16'(fault_n), 16'h0001);
	endtask : t_startup
	task automatic t_lock();
		wreg(ADDR_LOCK, 8'h01, 1'b0);
		rreg(ADDR_LOCK, 8'h01);
		wreg(ADDR_CFG, 8'h00, 1'b1);
		rreg(ADDR_CFG, 8'h68);
		nvwr(8'h20, 1'b0);
		wreg(ADDR_LOCK, 8'h01, 1'b0);
		rreg(ADDR_LOCK, 8'h00);
		@(negedge clk_i);
		flog = 1'b1;
		@(negedge clk_i);
		flog = 1'b0;
		rreg(ADDR_LOCK, 8'h02);
		nvwr(8'h11, 1'b0);
		nvwr(8'h12, 1'b1);
		wreg(ADDR_LOCK, 8'h02, 1'b0);
		rreg(ADDR_LOCK, 8'h00);
		nvwr(8'h05, 1'b1);
	endtask : t_lock
	task automatic finish_test();
		$display("checks %0d, mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : finish_test
	// Main sequence
	initial begin
		repeat (4) @(negedge clk_i);
		rst_i = 1'b0;
		t_regs();
		t_strobe();
		t_rstout();
		t_startup();
		t_lock();
		finish_test();
	end
	// Watchdog: the sequence needs about 2000 cycles
	initial begin
		#(40 * 20000);
		miscompares++;
		finish_test();
	end
endmodule : supervisor_watchdog_timer_tb
